// [core/intc_pkg.sv]
// Constants, register map and types for the external interrupt front end
package intc_pkg;
   // ==========================================================
   // Bus widths
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int IDX_W  = 16;
   localparam int IDX_LSB = 2;
   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [IDX_W-1:0] IDX_SYSCTL  = 16'hffc4;
   localparam logic [IDX_W-1:0] IDX_SENSE   = 16'hffc6;
   localparam logic [IDX_W-1:0] IDX_ENABLE  = 16'hffc7;
   localparam logic [IDX_W-1:0] IDX_KEYMASK = 16'hfff1;
   localparam logic [IDX_W-1:0] IDX_CPUMASK = 16'hffc0;
   localparam logic [IDX_W-1:0] IDX_STATUS  = 16'hffc1;
   // ==========================================================
   // Reset values and field positions
   localparam logic [7:0] SYSCTL_RST   = 8'h09;
   localparam logic [7:0] SYSCTL_WMASK = 8'hf7;
   localparam logic [7:0] SENSE_RST    = 8'h00;
   localparam logic [7:0] ENABLE_RST   = 8'h00;
   localparam logic [7:0] KEYMASK_RST  = 8'hbf;
   localparam logic       GMASK_RST    = 1'b1;
   localparam logic [7:0] PIN_IDLE     = 8'hff;
   localparam int NMI_EDGE_SELECT_BIT    = 2;
   localparam int GMASK_BIT    = 0;
   localparam int STAT_NMI_BIT = 8;
   localparam int NUM_LINES    = 8;
   localparam int KEY_LINE     = 6;
   localparam int NUM_PINS     = 17;
   localparam int NMI_PIN      = 16;
   // ==========================================================
   // Vectors and wake sources
   localparam logic [7:0] VEC_RESET    = 8'h00;
   localparam logic [7:0] VEC_NMI      = 8'h03;
   localparam logic [7:0] VEC_IRQ_BASE = 8'h04;
   localparam logic [7:0] WAKE_LINES   = 8'h47;
   // ==========================================================
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Register selected by an index
   typedef enum logic [2:0] {
      SEL_NONE, SEL_SYSCTL, SEL_SENSE, SEL_ENABLE,
      SEL_KEYMASK, SEL_CPUMASK, SEL_STATUS
   } reg_sel_t;
endpackage : intc_pkg

// [core/external_interrupt_front_end.sv]
// External interrupt front end: pin sensing, masking, priority and vectors
module external_interrupt_front_end (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic                       ce,
   input  wire logic [intc_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [intc_pkg::DATA_W-1:0] wdata,
   input  wire logic [3:0]                 wstrb,
   input  wire logic                       wvalid,
   output logic                            wready,
   output logic [1:0]                      bresp,
   output logic                            bvalid,
   input  wire logic                       bready,
   input  wire logic [intc_pkg::ADDR_W-1:0] araddr,
   input  wire logic                       arvalid,
   output logic                            arready,
   output logic [intc_pkg::DATA_W-1:0]     rdata,
   output logic [1:0]                      rresp,
   output logic                            rvalid,
   input  wire logic                       rready,
   input  wire logic                       nmi_n,
   input  wire logic [7:0]                 irq_n,
   input  wire logic [7:0]                 key_sense_input_n,
   input  wire logic                       hw_standby,
   input  wire logic                       sw_standby,
   input  wire logic                       irq_ack,
   output logic                            irq_req,
   output logic [7:0]                      irq_vector,
   output logic [15:0]                     vector_addr,
   output logic                            wake_req,
   output logic                            global_mask
);
   // ==========================================================
   // Helpers
   // Index decode shared by the write and read paths
   function automatic intc_pkg::reg_sel_t decode(
      input logic [intc_pkg::ADDR_W-1:0] addr);
      logic [intc_pkg::IDX_W-1:0] idx;
      idx = addr[intc_pkg::IDX_LSB +: intc_pkg::IDX_W];
      case (idx)
         intc_pkg::IDX_SYSCTL:  decode = intc_pkg::SEL_SYSCTL;
         intc_pkg::IDX_SENSE:   decode = intc_pkg::SEL_SENSE;
         intc_pkg::IDX_ENABLE:  decode = intc_pkg::SEL_ENABLE;
         intc_pkg::IDX_KEYMASK: decode = intc_pkg::SEL_KEYMASK;
         intc_pkg::IDX_CPUMASK: decode = intc_pkg::SEL_CPUMASK;
         intc_pkg::IDX_STATUS:  decode = intc_pkg::SEL_STATUS;
         default:               decode = intc_pkg::SEL_NONE;
      endcase
   endfunction : decode

   // Lowest set bit, which is the highest priority line
   function automatic logic [2:0] first_set(input logic [7:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = intc_pkg::NUM_LINES - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      first_set = r;
   endfunction : first_set

   // ==========================================================
   // Declarations
   logic                          aw_hold_r;
   logic [intc_pkg::ADDR_W-1:0]   aw_addr_r;
   logic                          w_hold_r;
   logic [7:0]                    w_byte_r;
   logic                          w_lane_r;
   logic                          bvalid_r;
   logic [1:0]                    bresp_r;
   logic                          rvalid_r;
   logic [1:0]                    rresp_r;
   logic [intc_pkg::DATA_W-1:0]   rdata_r;
   logic                          wr_fire;
   logic                          rd_fire;
   intc_pkg::reg_sel_t            wr_sel;
   intc_pkg::reg_sel_t            rd_sel;
   logic [7:0]                    sysctl_r;
   logic [7:0]                    sense_r;
   logic [7:0]                    enable_r;
   logic [7:0]                    keymask_r;
   logic                          gmask_r;
   logic [intc_pkg::NUM_PINS-1:0] sync1_r;
   logic [intc_pkg::NUM_PINS-1:0] sync2_r;
   logic [intc_pkg::NUM_PINS-1:0] sync3_r;
   logic [intc_pkg::NUM_PINS-1:0] filt_r;
   logic [intc_pkg::NUM_PINS-1:0] pins;
   logic [7:0]                    line_low;
   logic [7:0]                    line_low_prev_r;
   logic [7:0]                    line_fall;
   logic                          nmi_prev_r;
   logic                          nmi_edge;
   logic [7:0]                    pend_r;
   logic [7:0]                    pend_set;
   logic [7:0]                    pend_clr;
   logic                          nmi_pend_r;
   logic [7:0]                    req_line;
   logic [7:0]                    accepted;
   logic                          irq_req_r;
   logic [7:0]                    irq_vector_r;
   logic [15:0]                   vector_addr_r;
   logic                          wake_req_r;
   logic                          ack_now;
   logic                          ack_nmi;
   logic [7:0]                    ack_line;
   logic [7:0]                    vec_nxt;

   // ==========================================================
   // AXI4-Lite slave
   assign awready = ce & ~aw_hold_r;
   assign wready  = ce & ~w_hold_r;
   assign arready = ce & ~rvalid_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign rvalid  = rvalid_r;
   assign rresp   = rresp_r;
   assign rdata   = rdata_r;
   assign wr_fire = ce & aw_hold_r & w_hold_r & ~bvalid_r;
   assign rd_fire = arvalid & arready;
   assign wr_sel  = decode(aw_addr_r);
   assign rd_sel  = decode(araddr);

   // Write address capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (ce) begin
         if (awvalid && !aw_hold_r) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= awaddr;
         end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
         end
      end
   end

   // Write data capture, low byte lane only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_r <= 1'b0;
         w_byte_r <= 8'h00;
         w_lane_r <= 1'b0;
      end else if (ce) begin
         if (wvalid && !w_hold_r) begin
            w_hold_r <= 1'b1;
            w_byte_r <= wdata[7:0];
            w_lane_r <= wstrb[0];
         end else if (wr_fire) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= intc_pkg::RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (wr_sel == intc_pkg::SEL_NONE) ?
                        intc_pkg::RESP_SLVERR : intc_pkg::RESP_OKAY;
         end else if (bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Read data and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rresp_r  <= intc_pkg::RESP_OKAY;
         rdata_r  <= '0;
      end else if (ce) begin
         if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= intc_pkg::RESP_OKAY;
            rdata_r  <= '0;
            case (rd_sel)
               intc_pkg::SEL_SYSCTL:  rdata_r[7:0] <= sysctl_r;
               intc_pkg::SEL_SENSE:   rdata_r[7:0] <= sense_r;
               intc_pkg::SEL_ENABLE:  rdata_r[7:0] <= enable_r;
               intc_pkg::SEL_KEYMASK: rdata_r[7:0] <= keymask_r;
               intc_pkg::SEL_CPUMASK: rdata_r[intc_pkg::GMASK_BIT] <= gmask_r;
               intc_pkg::SEL_STATUS: begin
                  rdata_r[7:0] <= pend_r;
                  rdata_r[intc_pkg::STAT_NMI_BIT] <= nmi_pend_r;
               end
               default: rresp_r <= intc_pkg::RESP_SLVERR;
            endcase
         end else if (rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Control registers
   // NMI edge select storage; read-only bit keeps its value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sysctl_r <= intc_pkg::SYSCTL_RST;
      end else if (ce && wr_fire && w_lane_r && wr_sel == intc_pkg::SEL_SYSCTL) begin
         sysctl_r <= (w_byte_r & intc_pkg::SYSCTL_WMASK) |
                     (sysctl_r & ~intc_pkg::SYSCTL_WMASK);
      end
   end

   // Sense select and enable bits, cleared at reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sense_r  <= intc_pkg::SENSE_RST;
         enable_r <= intc_pkg::ENABLE_RST;
      end else if (ce && wr_fire && w_lane_r) begin
         if (wr_sel == intc_pkg::SEL_SENSE) begin
            sense_r <= w_byte_r;
         end
         if (wr_sel == intc_pkg::SEL_ENABLE) begin
            enable_r <= w_byte_r;
         end
      end
   end

   // Key mask, only key input 6 open after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         keymask_r <= intc_pkg::KEYMASK_RST;
      end else if (ce && wr_fire && w_lane_r && wr_sel == intc_pkg::SEL_KEYMASK) begin
         keymask_r <= w_byte_r;
      end
   end

   // Global mask set on acceptance, set beats a software clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gmask_r <= intc_pkg::GMASK_RST;
      end else if (ce) begin
         if (ack_now) begin
            gmask_r <= 1'b1;
         end else if (wr_fire && w_lane_r && wr_sel == intc_pkg::SEL_CPUMASK) begin
            gmask_r <= w_byte_r[intc_pkg::GMASK_BIT];
         end
      end
   end
   assign global_mask = gmask_r;

   // ==========================================================
   // Pin synchronisers and filter
   // Pin level only, no direction input exists
   assign pins = {nmi_n, key_sense_input_n, irq_n};

   // Three stages; a change counts when stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_r <= '1;
         sync2_r <= '1;
         sync3_r <= '1;
         filt_r  <= '1;
      end else if (ce) begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         filt_r  <= (sync2_r & ~(sync2_r ^ sync3_r)) | (filt_r & (sync2_r ^ sync3_r));
      end
   end

   // Unmasked key inputs join line 6
   always_comb begin
      line_low = ~filt_r[7:0];
      line_low[intc_pkg::KEY_LINE] = ~filt_r[intc_pkg::KEY_LINE] |
                                     (|(~filt_r[15:8] & ~keymask_r));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_low_prev_r <= ~intc_pkg::PIN_IDLE;
         nmi_prev_r      <= 1'b1;
      end else if (ce) begin
         line_low_prev_r <= line_low;
         nmi_prev_r      <= filt_r[intc_pkg::NMI_PIN];
      end
   end
   assign line_fall = line_low & ~line_low_prev_r;

   // Edge choice on the NMI line
   assign nmi_edge = sysctl_r[intc_pkg::NMI_EDGE_SELECT_BIT] ?
                     (filt_r[intc_pkg::NMI_PIN] & ~nmi_prev_r) :
                     (~filt_r[intc_pkg::NMI_PIN] & nmi_prev_r);

   // ==========================================================
   // Acknowledge decode
   assign ack_now = irq_ack & irq_req_r;
   assign ack_nmi = ack_now & (irq_vector_r == intc_pkg::VEC_NMI);
   always_comb begin
      for (int i = 0; i < intc_pkg::NUM_LINES; i++) begin
         ack_line[i] = ack_now & (irq_vector_r == intc_pkg::VEC_IRQ_BASE + 8'(i));
      end
   end

   // ==========================================================
   // Pending edge latches
   // Latch enabled edges; disabled lines take no new edges
   assign pend_set = sense_r & enable_r & line_fall;
   // Drop on mask with sense and enable both zero, or on service
   assign pend_clr = ack_line | ({8{gmask_r}} & ~sense_r & ~enable_r);

   // Set wins over clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_r <= 8'h00;
      end else if (ce) begin
         pend_r <= (pend_r & ~pend_clr) | pend_set;
      end
   end

   // NMI pending ignores the mask; not in hardware standby
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nmi_pend_r <= 1'b0;
      end else if (ce) begin
         nmi_pend_r <= (nmi_pend_r & ~ack_nmi) | (nmi_edge & ~hw_standby);
      end
   end

   // ==========================================================
   // Arbitration
   // Level requests while low, edge requests from latches
   assign req_line = pend_r | (~sense_r & enable_r & line_low);
   // Global mask blocks all eight lines
   assign accepted = gmask_r ? 8'h00 : req_line;

   always_comb begin
      if (nmi_pend_r) begin
         vec_nxt = intc_pkg::VEC_NMI;
      end else begin
         vec_nxt = intc_pkg::VEC_IRQ_BASE + {5'h00, first_set(accepted)};
      end
   end

   // One request forwarded; idle for a cycle after an acknowledge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_req_r <= 1'b0;
      end else if (ce) begin
         irq_req_r <= ~ack_now & (nmi_pend_r | (|accepted));
      end
   end

   // Reset vector address after reset; table entries are two bytes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_vector_r  <= intc_pkg::VEC_RESET;
         vector_addr_r <= {intc_pkg::VEC_RESET, 8'h00};
      end else if (ce && !ack_now && (nmi_pend_r || (|accepted))) begin
         irq_vector_r  <= vec_nxt;
         vector_addr_r <= {7'h00, vec_nxt, 1'b0};
      end
   end
   assign irq_req     = irq_req_r;
   assign irq_vector  = irq_vector_r;
   assign vector_addr = vector_addr_r;

   // Wake only from NMI and lines 0, 1, 2 and 6
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_req_r <= 1'b0;
      end else if (ce) begin
         wake_req_r <= sw_standby & (nmi_pend_r | (|(req_line & intc_pkg::WAKE_LINES)));
      end
   end
   assign wake_req = wake_req_r;

endmodule : external_interrupt_front_end

// [test/eifront_asserts.sv]
// Port checks for the external interrupt front end
module eifront_asserts (
   input wire logic                         aclk,
   input wire logic                         aresetn,
   input wire logic                         ce,
   input wire logic                         awvalid,
   input wire logic                         awready,
   input wire logic                         wvalid,
   input wire logic                         wready,
   input wire logic                         bvalid,
   input wire logic                         arvalid,
   input wire logic                         arready,
   input wire logic [intc_pkg::DATA_W-1:0] rdata,
   input wire logic                         rvalid,
   input wire logic                         rready,
   input wire logic                         sw_standby,
   input wire logic                         irq_ack,
   input wire logic                         irq_req,
   input wire logic [7:0]                   irq_vector,
   input wire logic [15:0]                  vector_addr,
   input wire logic                         wake_req,
   input wire logic                         global_mask
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // Named steps of the core link and register bus
   sequence ack_taken;
      irq_ack && irq_req;
   endsequence
   sequence write_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence read_taken;
      arvalid && arready;
   endsequence
   // ==========================================================
   // Assertions
   ack_mask_a: assert property (ack_taken |=> !irq_req && global_mask)
      else $error("accepted request did not drop or set the mask");
   req_stand_a: assert property (irq_req && !irq_ack |=> irq_req)
      else $error("request dropped before acceptance");
   vec_range_a: assert property (irq_req |-> irq_vector inside {[8'h03:8'h0b]})
      else $error("vector outside 3 to 11");
   vec_addr_a: assert property (irq_req |-> vector_addr == {7'h00, irq_vector, 1'b0})
      else $error("table address is not twice the vector");
   mask_block_a: assert property (
      $rose(irq_req) && $past(global_mask) && $past(global_mask, 2)
      |-> irq_vector == intc_pkg::VEC_NMI)
      else $error("masked line reached the core");
   wake_src_a: assert property (wake_req |-> $past(sw_standby))
      else $error("wake outside software standby");
   reset_out_a: assert property (
      $rose(aresetn) |-> !irq_req && global_mask && irq_vector == 8'h00)
      else $error("core link not idle after reset");
   ce_hold_a: assert property (!ce |-> !awready && !wready && !arready)
      else $error("bus ready while clock enable low");
   write_resp_a: assert property (write_taken |=> ##1 bvalid)
      else $error("write response late");
   read_resp_a: assert property (read_taken |=> rvalid)
      else $error("read data late");
   read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data not held");
endmodule : eifront_asserts

bind external_interrupt_front_end eifront_asserts eifront_asserts_inst (
   .aclk, .aresetn, .ce, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid,
   .arready, .rdata, .rvalid, .rready, .sw_standby, .irq_ack, .irq_req, .irq_vector,
   .vector_addr, .wake_req, .global_mask
);

// [test/core_model.sv]
// Processor core model that accepts forwarded requests
module core_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       irq_req,
   input  wire logic [7:0] irq_vector,
   input  wire logic [3:0] ack_delay,
   output logic            irq_ack,
   output logic [7:0]      taken_vec,
   output logic [7:0]      taken_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_r;
   // Accept one request after a wait
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_ack <= 1'b0;
         wait_r  <= 4'h0;
      end else begin
         irq_ack <= irq_req && !irq_ack && (wait_r >= ack_delay);
         wait_r  <= (irq_req && !irq_ack) ? wait_r + 4'h1 : 4'h0;
      end
   end
   // Latch the vector of each accepted request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         taken_vec <= 8'h00;
         taken_cnt <= 8'h00;
      end else if (irq_ack && irq_req) begin
         taken_vec <= irq_vector;
         taken_cnt <= taken_cnt + 8'h01;
      end
   end
endmodule : core_model

// [test/tb_external_interrupt_front_end.sv]
// Self-checking bench for the external interrupt front end
module tb_external_interrupt_front_end;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, nmi_n;
   logic hw_standby, sw_standby, awready, wready, bvalid, arready, rvalid;
   logic irq_ack, irq_req, wake_req, global_mask;
   logic [intc_pkg::ADDR_W-1:0] awaddr, araddr;
   logic [intc_pkg::DATA_W-1:0] wdata, rdata;
   logic [3:0]  wstrb, ack_delay;
   logic [1:0]  bresp, rresp;
   logic [7:0]  irq_n, key_sense_input_n, irq_vector, taken_vec, taken_cnt, base;
   logic [15:0] vector_addr;
   int          err_total, tests_run, cycles;

   external_interrupt_front_end external_interrupt_front_end_inst (.aclk, .aresetn, .ce,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .nmi_n,
      .irq_n, .key_sense_input_n, .hw_standby, .sw_standby, .irq_ack, .irq_req,
      .irq_vector, .vector_addr, .wake_req, .global_mask);
   core_model core_model_inst (.aclk, .aresetn, .irq_req, .irq_vector, .ack_delay,
      .irq_ack, .taken_vec, .taken_cnt);

   // ==========================================================
   // Clock and hang guard
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         $display("BAD timeout expected %0d seen %0d", 19999, cycles);
         summarize();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic bus(input bit wr_en, input logic [15:0] idx, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] resp);
      int   n;
      logic hs_a, hs_w, done;
      @(posedge aclk);
      awaddr  <= {idx, 2'b00};
      araddr  <= {idx, 2'b00};
      wdata   <= d;
      {awvalid, wvalid, bready} <= {3{wr_en}};
      arvalid <= !wr_en;
      done = 1'b0;
      for (n = 0; n < 40 && !done; n++) begin
         @(negedge aclk);
         hs_a = (awvalid && awready) || (arvalid && arready);
         hs_w = wvalid && wready;
         done = wr_en ? bvalid : rvalid && rready;
         resp = wr_en ? bresp : rresp;
         q    = rdata;
         @(posedge aclk);
         if (hs_a) {awvalid, arvalid} <= 2'b00;
         if (hs_w) wvalid <= 1'b0;
         rready <= !(wr_en | hs_a | done);
      end
      bready <= 1'b0;
      if (!done) chk("bus_answer", 32'h0, 32'h1);
   endtask : bus
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [31:0] q;
      logic [1:0]  r;
      bus(1'b1, idx, {24'h000000, d}, q, r);
      chk("write_resp", 32'(r), 32'(intc_pkg::RESP_OKAY));
   endtask : wr
   task automatic rd_chk(input string nm, input logic [15:0] idx, input logic [31:0] exp,
                         input logic [1:0] exp_r = intc_pkg::RESP_OKAY);
      logic [31:0] q;
      logic [1:0]  r;
      bus(1'b0, idx, 32'h0, q, r);
      chk({nm, "_resp"}, 32'(r), 32'(exp_r));
      if (exp_r == intc_pkg::RESP_OKAY) chk(nm, q, exp);
   endtask : rd_chk
   task automatic mark();
      repeat (10) @(negedge aclk);
      base = taken_cnt;
      @(posedge aclk);
   endtask : mark
   task automatic expect_take(input bit want, input logic [7:0] v);
      int n;
      for (n = 0; n < 30 && !(want && taken_cnt != base); n++) @(negedge aclk);
      chk("take_count", 32'(taken_cnt), 32'(base + 8'(want)));
      if (want) chk("vector", 32'(taken_vec), 32'(v));
      base = taken_cnt;
      @(posedge aclk);
   endtask : expect_take
   task automatic pulse(input logic [7:0] m);
      irq_n <= m;
      repeat (4) @(posedge aclk);
      irq_n <= 8'hff;
      repeat (8) @(posedge aclk);
   endtask : pulse
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      ce <= 1'b0;
      @(posedge aclk);
      ce <= 1'b1;
      rd_chk("system_control", intc_pkg::IDX_SYSCTL, 32'h09);
      rd_chk("irq_sense", intc_pkg::IDX_SENSE, 32'h00);
      rd_chk("irq_enable", intc_pkg::IDX_ENABLE, 32'h00);
      rd_chk("key_mask", intc_pkg::IDX_KEYMASK, 32'hbf);
      rd_chk("global_mask", intc_pkg::IDX_CPUMASK, 32'h01);
      rd_chk("unmapped", 16'h0000, 32'h0, intc_pkg::RESP_SLVERR);
      wr(intc_pkg::IDX_SYSCTL, 8'h00);
      rd_chk("sysctl_ro", intc_pkg::IDX_SYSCTL, 32'h08);
   endtask : t_reset
   task automatic t_nmi();
      mark();
      {nmi_n, hw_standby} <= 2'b01;
      expect_take(1'b0, 8'h00);
      {nmi_n, hw_standby} <= 2'b10;
      expect_take(1'b0, 8'h00);
      nmi_n <= 1'b0;
      expect_take(1'b1, intc_pkg::VEC_NMI);
      nmi_n <= 1'b1;
      wr(intc_pkg::IDX_SYSCTL, 8'h0d);
      mark();
      nmi_n <= 1'b0;
      expect_take(1'b0, 8'h00);
      nmi_n <= 1'b1;
      expect_take(1'b1, intc_pkg::VEC_NMI);
   endtask : t_nmi
   task automatic t_vectors();
      for (int i = 0; i < 8; i++) begin
         wr(intc_pkg::IDX_ENABLE, 8'h01 << i);
         irq_n <= ~(8'h01 << i);
         wr(intc_pkg::IDX_CPUMASK, 8'h00);
         expect_take(1'b1, intc_pkg::VEC_IRQ_BASE + 8'(i));
         chk("global_mask", 32'(global_mask), 32'h1);
         irq_n <= 8'hff;
      end
   endtask : t_vectors
   task automatic t_prio();
      ack_delay <= 4'h8;
      wr(intc_pkg::IDX_SENSE, 8'hff);
      wr(intc_pkg::IDX_ENABLE, 8'h0a);
      pulse(8'hf5);
      rd_chk("pending", intc_pkg::IDX_STATUS, 32'h0a);
      wr(intc_pkg::IDX_CPUMASK, 8'h00);
      expect_take(1'b1, 8'h05);
      wr(intc_pkg::IDX_CPUMASK, 8'h00);
      expect_take(1'b1, 8'h07);
      rd_chk("pending", intc_pkg::IDX_STATUS, 32'h00);
      ack_delay <= 4'h0;
   endtask : t_prio
   task automatic t_clear();
      wr(intc_pkg::IDX_ENABLE, 8'h04);
      pulse(8'hfb);
      wr(intc_pkg::IDX_ENABLE, 8'h00);
      rd_chk("pending", intc_pkg::IDX_STATUS, 32'h04);
      wr(intc_pkg::IDX_CPUMASK, 8'h00);
      expect_take(1'b1, 8'h06);
      wr(intc_pkg::IDX_ENABLE, 8'h04);
      pulse(8'hfb);
      wr(intc_pkg::IDX_ENABLE, 8'h00);
      rd_chk("pending", intc_pkg::IDX_STATUS, 32'h04);
      wr(intc_pkg::IDX_SENSE, 8'hfb);
      wr(intc_pkg::IDX_SENSE, 8'hff);
      pulse(8'hdb);
      rd_chk("pending", intc_pkg::IDX_STATUS, 32'h00);
   endtask : t_clear
   task automatic t_key_wake();
      wr(intc_pkg::IDX_SENSE, 8'h00);
      wr(intc_pkg::IDX_ENABLE, 8'h40);
      wr(intc_pkg::IDX_KEYMASK, 8'hbe);
      key_sense_input_n <= 8'hfd;
      wr(intc_pkg::IDX_CPUMASK, 8'h00);
      expect_take(1'b0, 8'h00);
      key_sense_input_n <= 8'hfe;
      expect_take(1'b1, 8'h0a);
      expect_take(1'b0, 8'h00);
      sw_standby <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("wake", 32'(wake_req), 32'h1);
      key_sense_input_n <= 8'hff;
      wr(intc_pkg::IDX_ENABLE, 8'h80);
      irq_n <= 8'h7f;
      repeat (8) @(posedge aclk);
      chk("wake", 32'(wake_req), 32'h0);
      {irq_n, sw_standby} <= {8'hff, 1'b0};
   endtask : t_key_wake

   // ==========================================================
   // Main sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, hw_standby, sw_standby} = '0;
      {ce, nmi_n, irq_n, key_sense_input_n} = {2'b11, 16'hffff};
      {awaddr, araddr, wdata, wstrb, ack_delay} = {36'h0, 32'h0, 4'h1, 4'h0};
      {err_total, tests_run, cycles, base} = '0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_nmi();
      t_vectors();
      t_prio();
      t_clear();
      t_key_wake();
      summarize();
   end
endmodule : tb_external_interrupt_front_end
